/* hdl/link_ctrl.sv */
// Two-wire serial link controller (master and slave) with AHB-Lite registers.
// Assumes SCL/SDA are open-drain wires with pull-ups resolved outside;
// the AHB-Lite master issues single word transfers.
//
// Notes on behaviour
// - Upper control nibble holds owner, direction, begin and end request bits.
// - Owner flag shows master/slave; direction flag shows transmit/receive.
// - Writing begin request starts master mode once bus free; bit stays set.
// - End request in master mode stops at the next stall, after any pending acknowledge cycle.
// - Both requests set in master mode give STOP then START.
// - Receiver: acknowledge bit sets sent value; transmitter: reads sampled value.
// - Acknowledge-needed flag sets after every received byte.
// - Software writes acknowledge before clearing event flag, else NACK sent.
// - SDA follows acknowledge write at once; SCL low until flag cleared.
// - Unacknowledged address byte ignores slave events until next START.
// - Arbitration-fail flag sets on loss while transmitting, master or slave.
// - Arbitration-fail flag clears whenever the event flag is cleared.
// - Event flag sets at transfer begin and end, per byte, on loss.
// - Event flag set mid-transfer stalls the link with SCL held low; after STOP or a loss SCL is left free.
// - Master read sends START, address with direction 1, then receives.
// - Master read drives SCL while slave data arrives on SDA.
// - Master receive raises event after each byte, before its acknowledge.
// - Acknowledge bit 1 sends ACK, 0 sends NACK.
// - Master receiver mode ends after end request and STOP, or on a data write.
// - Data write during master receive switches to master transmit.
`include "link_cfg.svh"

module link_ctrl #(
    parameter int HALF_CYC = (`LINK_HALF_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Serial clock pin
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    // Serial data pin
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);

    // ======================================================
    // Parameter check
    // Refused at elaboration: the divider and sync latency need at least 8
    if (HALF_CYC < 8 || HALF_CYC > 65535) begin : g_bad_half_cyc
        $error("HALF_CYC out of range");
    end

    // ======================================================
    // State and decoded events
    link_pkg::st_t  st;
    link_pkg::st_t  nxt;
    link_pkg::ctl_t wv;
    link_pkg::sel_t asel;

    logic       tick;
    logic       start_det;
    logic       stop_det;
    logic       scl_rise;
    logic       scl_fall;
    logic       addr_ok;
    logic       ctl_wr;
    logic       data_wr;
    logic       si_clr;
    logic       m_bit;
    logic       m_scl_low;
    logic       m_sda_low;
    logic       s_on;
    logic       s_sda_low;
    logic       s_scl_hold;
    logic [7:0] shf_in;

    assign tick      = (st.div == 16'h0000);
    assign start_det = st.scl_s2 & st.scl_p & st.sda_p & ~st.sda_s2;
    assign stop_det  = st.scl_s2 & st.scl_p & ~st.sda_p & st.sda_s2;
    assign scl_rise  = st.scl_s2 & ~st.scl_p;
    assign scl_fall  = ~st.scl_s2 & st.scl_p;
    assign shf_in    = {st.shf[6:0], st.sda_s2};

    // ======================================================
    // Bus decode
    assign addr_ok = hsel & htrans[1] & hready;
    assign wv      = link_pkg::ctl_t'(hwdata[7:0]);
    assign ctl_wr  = st.wr_pend & (st.wr_sel == link_pkg::SEL_CTL);
    assign data_wr = st.wr_pend & (st.wr_sel == link_pkg::SEL_DATA);
    assign si_clr  = ctl_wr & ~wv.si & st.ctl.si;

    always_comb begin
        case (haddr[7:0])
            `OFS_CTRL: asel = link_pkg::SEL_CTL;
            `OFS_DATA: asel = link_pkg::SEL_DATA;
            `OFS_CFG:  asel = link_pkg::SEL_CFG;
            default:   asel = link_pkg::SEL_NONE;
        endcase
    end

    // ======================================================
    // Pin drive
    // Receive ack slot follows the ack bit combinationally
    assign m_bit = (st.cnt == 4'h8) ? ~(st.ackpend & st.ctl.ack)
                                    : (~st.ctl.transmit_direction_flag | st.shf[7]);

    always_comb begin
        case (st.mst)
            link_pkg::M_START: begin
                m_scl_low = 1'b0;
                m_sda_low = 1'b1;
            end
            link_pkg::M_LOW: begin
                m_scl_low = 1'b1;
                m_sda_low = ~m_bit;
            end
            link_pkg::M_HIGH: begin
                m_scl_low = 1'b0;
                m_sda_low = ~m_bit;
            end
            link_pkg::M_STALL: begin
                m_scl_low = 1'b1;
                m_sda_low = st.ackpend & st.ctl.ack;
            end
            link_pkg::M_STOP1: begin
                m_scl_low = 1'b1;
                m_sda_low = 1'b1;
            end
            link_pkg::M_STOP2: begin
                m_scl_low = 1'b0;
                m_sda_low = 1'b1;
            end
            default: begin
                m_scl_low = 1'b0;
                m_sda_low = 1'b0;
            end
        endcase
    end

    assign s_on       = st.s_act & ~st.s_ign & ~st.ctl.master;
    assign s_sda_low  = s_on & (st.s_tx ? (st.cnt <= 4'h7 && !st.shf[7])
                                        : (st.cnt == 4'h8 && st.ctl.ack));
    // Stretch only once the clock is already low, never pull mid-high
    assign s_scl_hold = st.ctl.si & s_on & ~st.scl_s2;

    assign scl_out   = 1'b0;
    assign sda_out   = 1'b0;
    assign scl_oe    = m_scl_low | s_scl_hold;
    assign sda_oe    = m_sda_low | s_sda_low;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st.hrdata;

    // ======================================================
    // Next state
    always_comb begin
        nxt = st;
        nxt.div    = tick ? 16'(HALF_CYC - 1) : st.div - 16'h0001;
        nxt.scl_s1 = scl_in;
        nxt.scl_s2 = st.scl_s1;
        nxt.scl_p  = st.scl_s2;
        nxt.sda_s1 = sda_in;
        nxt.sda_s2 = st.sda_s1;
        nxt.sda_p  = st.sda_s2;

        // Bus slave: zero wait, read data captured in address phase
        nxt.wr_pend = addr_ok & hwrite;
        nxt.wr_sel  = asel;
        if (addr_ok && !hwrite) begin
            case (asel)
                link_pkg::SEL_CTL:  nxt.hrdata = {24'h000000, st.ctl};
                link_pkg::SEL_DATA: nxt.hrdata = {24'h000000, st.data};
                link_pkg::SEL_CFG:  nxt.hrdata = {31'h00000000, st.en};
                default:            nxt.hrdata = 32'h00000000;
            endcase
        end

        // Software writes first so hardware sets below win
        if (ctl_wr) begin
            nxt.ctl.begin_condition_request = wv.begin_condition_request;
            nxt.ctl.end_condition_request = wv.end_condition_request;
            nxt.ctl.ack = wv.ack;
            if (!wv.si) begin
                nxt.ctl.si = 1'b0;
            end
        end
        if (si_clr) begin
            nxt.ctl.arb   = 1'b0;
            nxt.ctl.acknowledge_needed_flag = 1'b0;
            if (s_on && st.s_tx) begin
                nxt.shf = st.data;
            end
        end
        if (data_wr) begin
            nxt.data = hwdata[7:0];
            if (st.ctl.master && !st.ctl.transmit_direction_flag) begin
                nxt.ctl.transmit_direction_flag = 1'b1;
            end
        end
        if (st.wr_pend && st.wr_sel == link_pkg::SEL_CFG) begin
            nxt.en = hwdata[0];
        end

        // Bus monitor
        if (start_det) begin
            nxt.busy  = 1'b1;
            nxt.s_ign = 1'b0;
        end
        if (stop_det) begin
            nxt.busy = 1'b0;
        end

        // Slave side
        if (!st.ctl.master && st.mst == link_pkg::M_IDLE) begin
            if (start_det) begin
                nxt.ctl.begin_condition_request    = 1'b1;
                nxt.ctl.transmit_direction_flag = 1'b0;
                nxt.s_act      = st.en;
                nxt.s_addr     = 1'b1;
                nxt.s_tx       = 1'b0;
                nxt.cnt        = 4'hf;
            end else if (stop_det) begin
                nxt.ctl.end_condition_request = 1'b1;
                nxt.s_act   = 1'b0;
                if (s_on) begin
                    nxt.ctl.si = 1'b1;
                end
            end else if (s_on && scl_rise) begin
                if (st.cnt <= 4'h7) begin
                    if (st.s_tx && st.shf[7] && !st.sda_s2) begin
                        nxt.ctl.arb = 1'b1;
                        nxt.ctl.si  = 1'b1;
                        nxt.s_act   = 1'b0;
                    end else if (!st.s_tx) begin
                        nxt.shf = shf_in;
                    end
                end else if (st.cnt == 4'h8 && st.s_tx) begin
                    nxt.s_ackin = ~st.sda_s2;
                end
            end else if (s_on && scl_fall) begin
                if (st.cnt == 4'hf) begin
                    nxt.cnt = 4'h0;
                end else if (st.cnt == 4'h8) begin
                    nxt.cnt = 4'h0;
                    if (st.s_addr) begin
                        nxt.s_addr = 1'b0;
                        if (!st.ctl.ack) begin
                            nxt.s_ign = 1'b1;
                        end else if (st.rw) begin
                            nxt.s_tx       = 1'b1;
                            nxt.ctl.transmit_direction_flag = 1'b1;
                            nxt.ctl.si     = 1'b1;
                        end
                    end else if (st.s_tx) begin
                        nxt.ctl.ack = st.s_ackin;
                        nxt.ctl.si  = 1'b1;
                    end
                end else begin
                    nxt.cnt = st.cnt + 4'h1;
                    if (st.s_tx && st.cnt != 4'h7) begin
                        nxt.shf = {st.shf[6:0], 1'b1};
                    end
                    if (!st.s_tx && st.cnt == 4'h7) begin
                        nxt.data      = st.shf;
                        nxt.rw        = st.shf[0];
                        nxt.ctl.si    = 1'b1;
                        nxt.ctl.acknowledge_needed_flag = 1'b1;
                        nxt.ctl.ack   = 1'b0;
                    end
                end
            end
        end

        // Master sequencer
        case (st.mst)
            link_pkg::M_IDLE: begin
                if (tick && st.en && st.ctl.begin_condition_request && !st.busy && !s_on) begin
                    nxt.mst        = link_pkg::M_START;
                    nxt.ctl.master = 1'b1;
                    nxt.ctl.transmit_direction_flag = 1'b1;
                    nxt.addr_byte  = 1'b1;
                    nxt.s_act      = 1'b0;
                end
            end
            link_pkg::M_START: begin
                if (tick) begin
                    nxt.mst     = link_pkg::M_STALL;
                    nxt.cnt     = 4'h0;
                    nxt.ackpend = 1'b0;
                    nxt.ctl.si  = 1'b1;
                end
            end
            link_pkg::M_STALL: begin
                if (!st.ctl.si && tick) begin
                    if (st.ackpend) begin
                        nxt.mst = link_pkg::M_LOW;
                    end else if (st.ctl.end_condition_request) begin
                        nxt.mst = link_pkg::M_STOP1;
                    end else begin
                        nxt.mst = link_pkg::M_LOW;
                        nxt.cnt = 4'h0;
                        nxt.shf = st.ctl.transmit_direction_flag ? st.data : 8'hff;
                        if (st.addr_byte) begin
                            nxt.rw = st.data[0];
                        end
                    end
                end
            end
            link_pkg::M_LOW: begin
                if (tick) begin
                    nxt.mst = link_pkg::M_HIGH;
                end
            end
            link_pkg::M_HIGH: begin
                if (tick && st.scl_s2) begin
                    if (st.cnt <= 4'h7) begin
                        if (st.ctl.transmit_direction_flag && st.shf[7] && !st.sda_s2) begin
                            nxt.ctl.arb    = 1'b1;
                            nxt.ctl.si     = 1'b1;
                            nxt.ctl.master = 1'b0;
                            nxt.mst        = link_pkg::M_IDLE;
                        end else begin
                            nxt.shf = shf_in;
                            nxt.cnt = st.cnt + 4'h1;
                            nxt.mst = link_pkg::M_LOW;
                            if (!st.ctl.transmit_direction_flag && st.cnt == 4'h7) begin
                                nxt.data      = shf_in;
                                nxt.ackpend   = 1'b1;
                                nxt.ctl.si    = 1'b1;
                                nxt.ctl.acknowledge_needed_flag = 1'b1;
                                nxt.ctl.ack   = 1'b0;
                                nxt.mst       = link_pkg::M_STALL;
                            end
                        end
                    end else if (st.ackpend) begin
                        nxt.ackpend = 1'b0;
                        nxt.mst     = link_pkg::M_STALL;
                    end else begin
                        nxt.ctl.ack = ~st.sda_s2;
                        if (st.addr_byte && st.rw) begin
                            nxt.ctl.transmit_direction_flag = 1'b0;
                        end
                        nxt.addr_byte = 1'b0;
                        nxt.ctl.si    = 1'b1;
                        nxt.mst       = link_pkg::M_STALL;
                    end
                end
            end
            link_pkg::M_STOP1: begin
                if (tick) begin
                    nxt.mst = link_pkg::M_STOP2;
                end
            end
            link_pkg::M_STOP2: begin
                if (tick && st.scl_s2) begin
                    nxt.mst = link_pkg::M_STOP3;
                end
            end
            link_pkg::M_STOP3: begin
                // Wait a half period so our own STOP is seen while busy here
                if (tick) begin
                    nxt.mst        = link_pkg::M_IDLE;
                    nxt.ctl.master = 1'b0;
                    nxt.ctl.transmit_direction_flag = 1'b0;
                    nxt.ctl.end_condition_request    = 1'b0;
                    nxt.ctl.si     = 1'b1;
                end
            end
            default: begin
                nxt.mst = link_pkg::M_IDLE;
            end
        endcase

        if (!st.en) begin
            nxt.s_act = 1'b0;
        end
    end

    // ======================================================
    // State register
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st        <= '0;
            st.ctl    <= link_pkg::ctl_t'(`RST_CTRL);
            st.data   <= `RST_DATA;
            st.en     <= 1'b0;
            st.mst    <= link_pkg::M_IDLE;
            st.wr_sel <= link_pkg::SEL_NONE;
            st.scl_s1 <= 1'b1;
            st.scl_s2 <= 1'b1;
            st.scl_p  <= 1'b1;
            st.sda_s1 <= 1'b1;
            st.sda_s2 <= 1'b1;
            st.sda_p  <= 1'b1;
        end else begin
            st <= nxt;
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_STALL_SCL: assert property ((st.mst == link_pkg::M_STALL) |-> scl_oe)
        else $error("SCL not held low in stall");

    AST_ARB_CLEAR: assert property (si_clr |=> (!st.ctl.arb || st.ctl.si))
        else $error("arbitration flag survived event clear");

    AST_ACKNOWLEDGE_NEEDED_FLAG_NACK: assert property ($rose(st.ctl.acknowledge_needed_flag) |-> !st.ctl.ack)
        else $error("ack not defaulted to NACK");

    AST_STA_KEPT: assert property ((st.mst == link_pkg::M_START && !ctl_wr) |=> st.ctl.begin_condition_request)
        else $error("begin request cleared by hardware");

    AST_RX_EVENT: assert property (($rose(st.ctl.acknowledge_needed_flag) && st.ctl.master)
        |-> (st.ackpend && st.mst == link_pkg::M_STALL))
        else $error("receive event not before ack cycle");

    AST_ACK_DRIVE: assert property ((st.mst == link_pkg::M_LOW && st.cnt == 4'h8 && st.ackpend)
        |-> (sda_oe == st.ctl.ack))
        else $error("ack slot drive wrong");

    AST_IGNORE_HOLD: assert property ((st.s_ign && !start_det) |=> st.s_ign)
        else $error("ignore state left without START");

    AST_READ_DIR: assert property ((st.mst == link_pkg::M_HIGH && tick && st.scl_s2
        && st.cnt == 4'h8 && !st.ackpend && st.addr_byte && st.rw && !data_wr)
        |=> (!st.ctl.transmit_direction_flag && st.ctl.si))
        else $error("read address did not enter receive");

    AST_TX_SWITCH: assert property ((data_wr && st.ctl.master) |=> st.ctl.transmit_direction_flag)
        else $error("data write did not select transmit");

    AST_STOP_END: assert property ((st.mst == link_pkg::M_STOP3 && tick)
        |=> (!st.ctl.master && !st.ctl.end_condition_request && st.mst == link_pkg::M_IDLE))
        else $error("master not released after STOP");

    AST_STOP_ORDER: assert property ((st.mst == link_pkg::M_STOP2)
        |-> ##[1:300] (st.mst == link_pkg::M_STOP3))
        else $error("STOP sequence stuck");

endmodule // link_ctrl

/* hdl/link_cfg.svh */
// Register offsets, reset values and timing constants of the two-wire link
// controller. Definitions only; included by bare name.
`ifndef LINK_CFG_SVH
`define LINK_CFG_SVH

// ==========================================================
// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_DATA      8'h04
`define OFS_CFG       8'h08

// ==========================================================
// Reset values
`define RST_CTRL      8'h00
`define RST_DATA      8'h00
`define RST_CFG       8'h00

// ==========================================================
// Timing: half period of the generated serial clock
`define LINK_HALF_NS  1250
`define CORE_CLK_NS   8

`endif

/* hdl/link_pkg.sv */
// Types of the two-wire link controller: control vector, master sequencer
// states, register select and the complete state record.
package link_pkg;

    // ======================================================
    // Control/status byte, MSB first
    typedef struct packed {
        logic master;
        logic transmit_direction_flag;
        logic begin_condition_request;
        logic end_condition_request;
        logic acknowledge_needed_flag;
        logic arb;
        logic ack;
        logic si;
    } ctl_t;

    // ======================================================
    // Master sequencer, Gray along idle-start-stall-low-high
    typedef enum logic [2:0] {
        M_IDLE  = 3'h0,
        M_START = 3'h1,
        M_STALL = 3'h3,
        M_LOW   = 3'h2,
        M_HIGH  = 3'h6,
        M_STOP1 = 3'h7,
        M_STOP2 = 3'h5,
        M_STOP3 = 3'h4
    } mst_state_t;

    typedef enum logic [1:0] {
        SEL_NONE = 2'h0,
        SEL_CTL  = 2'h1,
        SEL_DATA = 2'h2,
        SEL_CFG  = 2'h3
    } sel_t;

    // ======================================================
    // Whole module state
    typedef struct packed {
        ctl_t        ctl;
        logic [7:0]  data;
        logic        en;
        logic [7:0]  shf;
        logic [3:0]  cnt;
        mst_state_t  mst;
        logic [15:0] div;
        logic        addr_byte;
        logic        rw;
        logic        ackpend;
        logic        s_act;
        logic        s_ign;
        logic        s_tx;
        logic        s_addr;
        logic        s_ackin;
        logic        busy;
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_p;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_p;
        logic        wr_pend;
        sel_t        wr_sel;
        logic [31:0] hrdata;
    } st_t;

endpackage

/* test/link_target_model.sv */
// Behavioural target on the two-wire bus: answers one address, sends a byte.
// Assumes the bench resolves both wires with pull-ups.
module link_target_model (
    // Wire levels
    input  wire logic       scl,
    input  wire logic       sda,
    // Target settings
    input  wire logic [6:0] own_addr,
    input  wire logic [7:0] tx_byte,
    // Open-drain pull and stop count
    output logic            sda_low,
    output int              stops
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;
    // ==========================================
    // Address, acknowledge, read data
    initial begin
        sda_low = 1'b0;
        forever begin
            @(negedge sda iff scl);
            for (int i = 7; i >= 0; i--) begin
                @(posedge scl);
                sh[i] = sda;
            end
            @(negedge scl);
            sda_low = (sh[7:1] == own_addr);
            @(negedge scl);
            sda_low = 1'b0;
            // Released after the last bit so the master owns the ack slot
            if (sh[7:1] == own_addr && sh[0]) begin
                for (int i = 7; i >= 0; i--) begin
                    sda_low = ~tx_byte[i];
                    @(negedge scl);
                end
                sda_low = 1'b0;
            end
        end
    end
    initial stops = 0;
    always @(posedge sda) if (scl) stops++;
endmodule // link_target_model

/* test/link_ctrl_tb.sv */
// Bench for the link controller: AHB-Lite register access, one master read.
// Assumes pull-ups on both wires and a single behavioural target.
`include "link_cfg.svh"
module link_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, obs, v;
    logic        hready, hreadyout, hresp, scl_oe, sda_oe, sda_low;
    logic [6:0]  tgt = 7'h0;
    logic [7:0]  txb = 8'h0;
    logic [31:0] q_e[$], q_m[$];
    int          miscompares = 0, samples_checked = 0, stops, stops0;
    event        got;
    wire         scl = ~scl_oe;
    wire         sda = ~(sda_oe | sda_low);
    assign hready = hreadyout;
    always #4 core_clk = ~core_clk;
    link_ctrl #(.HALF_CYC(8)) i_link_ctrl (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
    link_target_model i_link_target_model (.scl(scl), .sda(sda), .own_addr(tgt), .tx_byte(txb),
        .sda_low(sda_low), .stops(stops));
    // ==========================================
    // Result watcher
    always @(got) begin
        samples_checked++;
        if ((obs & q_m[0]) !== q_e[0]) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, obs & q_m[0], q_e[0]);
        end
        void'(q_e.pop_front());
        void'(q_m.pop_front());
    end
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic probe(input logic [31:0] val, input logic [31:0] ex, input logic [31:0] m);
        q_e.push_back(ex);
        q_m.push_back(m);
        obs = val;
        ->got;
        #1;
    endtask
    // ==========================================
    // Bus cycles
    task automatic edge_rdy();
        int n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        edge_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        edge_rdy();
        rd = hrdata;
        // Idle slot so a following read sees the write
        @(posedge core_clk);
    endtask
    // Polling is bounded: a stuck link ends the run
    task automatic wait_si(output logic [31:0] r);
        int n = 0;
        do begin
            xfer(1'b0, `OFS_CTRL, 32'h0, r);
            n++;
        end while (r[0] !== 1'b1 && n < 300);
        if (r[0] !== 1'b1) begin
            miscompares++;
            conclude();
        end
    endtask
    // ==========================================
    // Master read sequence
    initial begin
        void'($urandom(25));
        tgt <= 7'($urandom);
        txb <= 8'($urandom);
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        // Wires leave unknown at the first edge; count STOPs from here on
        stops0 = stops;
        xfer(1'b0, `OFS_CTRL, 32'h0, v);
        probe(v, 32'h0, 32'hff);
        probe({31'h0, hresp}, 32'h0, 32'h1);
        xfer(1'b0, 8'h0c, 32'h0, v);
        probe(v, 32'h0, 32'hffffffff);
        xfer(1'b1, `OFS_CFG, 32'h1, v);
        xfer(1'b1, `OFS_CTRL, 32'h20, v);
        wait_si(v);
        probe(v, 32'he1, 32'hff);
        probe({31'h0, scl_oe}, 32'h1, 32'h1);
        xfer(1'b1, `OFS_DATA, {24'h0, tgt, 1'b1}, v);
        xfer(1'b1, `OFS_CTRL, 32'h0, v);
        wait_si(v);
        probe(v, 32'h83, 32'hc3);
        xfer(1'b1, `OFS_CTRL, 32'h0, v);
        wait_si(v);
        probe(v, 32'h89, 32'hcb);
        xfer(1'b0, `OFS_DATA, 32'h0, v);
        probe(v, {24'h0, txb}, 32'hffffffff);
        xfer(1'b1, `OFS_CTRL, 32'h03, v);
        probe({31'h0, sda_oe}, 32'h1, 32'h1);
        xfer(1'b1, `OFS_CTRL, 32'h01, v);
        probe({31'h0, sda_oe}, 32'h0, 32'h1);
        xfer(1'b1, `OFS_CTRL, 32'h10, v);
        wait_si(v);
        probe(v, 32'h01, 32'hd1);
        probe(32'(stops - stops0), 32'h1, 32'hffffffff);
        conclude();
    end
endmodule // link_ctrl_tb
